// >>> design/rhi_pkg.sv
// constants shared by the peripheral and the clock module
package rhi_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RD_LAT_HZ = 12_000_000;
  localparam int unsigned RD_LAT_CYC = (CLK_HZ + RD_LAT_HZ - 1) / RD_LAT_HZ;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned OSC_DIV = 256;
  localparam int unsigned PHASE_DIV = 128;
  localparam int unsigned EXEC_TICKS = OSC_HZ / OSC_DIV;
  localparam int unsigned SCK_HALF = 4;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned PHASE_W = 7;
  localparam int unsigned DIV_W = 8;
  localparam int unsigned ADR_W = 18;
  localparam int unsigned IDX_W = 16;
  localparam int unsigned OP_MSB = 31;
  localparam int unsigned OP_LSB = 24;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_DATA_LOW = 16'hfea0;
  localparam logic [15:0] IDX_DATA_HIGH = 16'hfea1;
  localparam logic [15:0] IDX_CTRL = 16'hfea2;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [4:0] CTRL_RST = 5'h00;

  // ---------------------------------------------------------------
  // control/status fields
  // ---------------------------------------------------------------
  localparam int unsigned CF_IBUSY = 0;
  localparam int unsigned CF_DBUSY = 1;
  localparam int unsigned CF_RDBUSY = 2;
  localparam int unsigned CF_EXEC = 3;
  localparam int unsigned CF_GSCK = 4;
  localparam int unsigned CF_W = 5;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RESET = 8'heb;
  localparam logic [7:0] OP_LOAD_TIME = 8'h59;
  localparam logic [7:0] OP_READ_TIME = 8'h56;
  localparam logic [7:0] OP_READ_SUBSEC = 8'hc7;
  localparam logic [7:0] OP_ALARM = 8'hac;

  typedef enum logic [1:0] {KIND_INSTR, KIND_DATA, KIND_READ} rhi_kind_e;

endpackage : rhi_pkg

// >>> design/rhi_link_if.sv
// serial link between the bus peripheral and the clock module
`timescale 1ns/1ps
`default_nettype none
interface rhi_link_if;
  logic sck;
  logic cs;
  logic mosi;
  rhi_pkg::rhi_kind_e kind;
  logic exec;
  logic miso;
  logic ready;

  modport periph (output sck, output cs, output mosi, output kind, output exec, input miso, input ready);
  modport clkmod (input sck, input cs, input mosi, input kind, input exec, output miso, output ready);
endinterface : rhi_link_if
`default_nettype wire

// >>> design/rhi_clock_module.sv
// separately powered seconds counter module with prescaler and alarm
`timescale 1ns/1ps
`default_nettype none
module rhi_clock_module #(
  parameter int unsigned OSC_DIV = rhi_pkg::OSC_DIV,
  parameter int unsigned PHASE_DIV = rhi_pkg::PHASE_DIV
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // link
  rhi_link_if.clkmod lnk,
  // user side
  input wire logic i_osc_32k,
  output logic o_alarm,
  output logic [31:0] o_seconds
);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  if (OSC_DIV < 2 || OSC_DIV > 256 || PHASE_DIV < 2 || PHASE_DIV > 128) begin : g_bad
    $error("rhi_clock_module: divider out of range");
  end

  typedef enum {M_IDLE, M_SAMPLE, M_XFER, M_TAKE} rhi_mst_e;

  rhi_mst_e st_reg;
  logic osc_meta_reg, osc_sync_reg, osc_prev_reg;
  logic [7:0] div_reg;
  logic [6:0] phase_reg;
  logic [31:0] sec_reg;
  logic [31:0] sh_reg;
  logic [31:0] buf_reg;
  logic [7:0] instr_reg;
  logic [7:0] exec_cnt_reg;
  logic exec_done_reg;
  logic pend_rst_reg, pend_alarm_reg;
  logic [31:0] alarm_reg;
  logic alarm_en_reg;
  logic [3:0] lat_reg;
  logic sck_q_reg, rx_reg;
  logic [31:0] rd_word;
  logic osc_edge, tick128, sec_tick, sck_rise, sck_fall, exec_fire, long_op;

  // ---------------------------------------------------------------
  // oscillator and prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_meta_reg <= i_osc_32k;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
    end
  end

  assign osc_edge = osc_sync_reg & ~osc_prev_reg;
  assign tick128 = osc_edge && (div_reg == 8'(OSC_DIV - 1));
  assign sec_tick = tick128 && (phase_reg == 7'(PHASE_DIV - 1));

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg <= 8'h00;
      phase_reg <= 7'h00;
    end else if (exec_fire && instr_reg == rhi_pkg::OP_LOAD_TIME) begin
      div_reg <= 8'h00;
      phase_reg <= 7'h00;
    end else if (osc_edge) begin
      div_reg <= tick128 ? 8'h00 : div_reg + 8'h01;
      if (tick128) begin
        phase_reg <= sec_tick ? 7'h00 : phase_reg + 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // seconds counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sec_reg <= 32'h0000_0000;
    end else if (exec_fire && instr_reg == rhi_pkg::OP_LOAD_TIME) begin
      sec_reg <= buf_reg;
    end else if (sec_tick) begin
      sec_reg <= sec_reg + 32'h0000_0001;
    end
  end

  assign o_seconds = sec_reg;

  // ---------------------------------------------------------------
  // execute timing: exec must stand 128 prescaler ticks, a full second at the default dividers
  // ---------------------------------------------------------------
  assign long_op = (instr_reg == rhi_pkg::OP_RESET) || (instr_reg == rhi_pkg::OP_LOAD_TIME);
  assign exec_fire = lnk.exec && long_op && !exec_done_reg && tick128
                     && (exec_cnt_reg == 8'(rhi_pkg::EXEC_TICKS - 1));

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      exec_cnt_reg <= 8'h00;
      exec_done_reg <= 1'b0;
    end else if (!lnk.exec || !long_op) begin
      exec_cnt_reg <= 8'h00;
      exec_done_reg <= 1'b0;
    end else if (exec_fire) begin
      exec_done_reg <= 1'b1; // runs once per exec assertion
    end else if (tick128 && !exec_done_reg) begin
      exec_cnt_reg <= exec_cnt_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // alarm and reset instructions, applied at the next 1/128 s tick
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_rst_reg <= 1'b0;
      pend_alarm_reg <= 1'b0;
      alarm_reg <= 32'h0000_0000;
      alarm_en_reg <= 1'b0;
    end else begin
      if (exec_fire && instr_reg == rhi_pkg::OP_RESET) begin
        pend_rst_reg <= 1'b1;
      end else if (tick128) begin
        pend_rst_reg <= 1'b0;
      end
      if (st_reg == M_TAKE && lnk.kind == rhi_pkg::KIND_INSTR && sh_reg[31:24] == rhi_pkg::OP_ALARM) begin
        pend_alarm_reg <= 1'b1;
      end else if (tick128) begin
        pend_alarm_reg <= 1'b0;
      end
      if (tick128 && pend_rst_reg) begin
        alarm_en_reg <= 1'b0;
        alarm_reg <= 32'h0000_0000;
      end else if (tick128 && pend_alarm_reg) begin
        alarm_reg <= buf_reg;
        alarm_en_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_alarm <= 1'b0;
    end else begin
      o_alarm <= alarm_en_reg && (sec_reg == alarm_reg);
    end
  end

  // ---------------------------------------------------------------
  // serial link
  // ---------------------------------------------------------------
  assign sck_rise = lnk.sck & ~sck_q_reg;
  assign sck_fall = ~lnk.sck & sck_q_reg;
  assign lnk.miso = sh_reg[31];
  assign lnk.ready = lnk.cs ? (st_reg == M_XFER) : (st_reg == M_IDLE);
  assign rd_word = (instr_reg == rhi_pkg::OP_READ_SUBSEC) ? {25'h0, phase_reg} : sec_reg;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= M_IDLE;
      sh_reg <= 32'h0000_0000;
      lat_reg <= 4'h0;
      sck_q_reg <= 1'b0;
      rx_reg <= 1'b0;
    end else begin
      sck_q_reg <= lnk.sck;
      unique case (st_reg)
        M_IDLE: begin
          lat_reg <= 4'h0;
          if (lnk.cs) begin
            st_reg <= (lnk.kind == rhi_pkg::KIND_READ) ? M_SAMPLE : M_XFER;
          end
        end
        M_SAMPLE: begin
          lat_reg <= lat_reg + 4'h1;
          if (lat_reg == 4'(rhi_pkg::RD_LAT_CYC - 1)) begin
            sh_reg <= rd_word;
            st_reg <= M_XFER;
          end
        end
        M_XFER: begin
          if (sck_rise) begin
            rx_reg <= lnk.mosi;
          end
          if (sck_fall) begin
            sh_reg <= {sh_reg[30:0], rx_reg};
          end
          if (!lnk.cs) begin
            st_reg <= M_TAKE;
          end
        end
        M_TAKE: st_reg <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      instr_reg <= 8'h00;
      buf_reg <= 32'h0000_0000;
    end else if (st_reg == M_SAMPLE && lat_reg == 4'(rhi_pkg::RD_LAT_CYC - 1)) begin
      buf_reg <= rd_word; // sample lands in the buffer in the same cycle as the shift register
    end else if (st_reg == M_TAKE) begin
      if (lnk.kind == rhi_pkg::KIND_INSTR) begin
        instr_reg <= sh_reg[31:24];
      end else if (lnk.kind == rhi_pkg::KIND_DATA) begin
        buf_reg <= sh_reg;
      end
    end
  end

endmodule : rhi_clock_module
`default_nettype wire

// >>> design/rhi_periph.sv
// bus-side peripheral: data and control/status registers, serial link master
`timescale 1ns/1ps
`default_nettype none
module rhi_periph #(
  parameter int unsigned SCK_HALF = rhi_pkg::SCK_HALF
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [17:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // link to the clock module
  rhi_link_if.periph lnk
);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  if (SCK_HALF < 2 || SCK_HALF > 255) begin : g_bad
    $error("rhi_periph: SCK_HALF must lie in 2..255");
  end

  typedef enum {P_IDLE, P_PREP, P_SHIFT, P_DONE} rhi_pst_e;

  rhi_pst_e st_reg;
  logic [15:0] low_reg, high_reg;
  logic [2:0] busy_reg;
  logic exec_reg, gsck_reg;
  logic [31:0] sh_reg;
  logic [7:0] half_reg;
  logic [4:0] bit_reg;
  logic sck_reg, cs_reg, rx_reg;
  rhi_pkg::rhi_kind_e kind_reg;
  logic [15:0] idx;
  logic wb_req, wr_low, wr_high, wr_ctrl, launch, xfer_done;
  logic [2:0] launch_bits;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  assign idx = i_wb_adr[17:2];
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_low = wb_req & i_wb_we & (idx == rhi_pkg::IDX_DATA_LOW);
  assign wr_high = wb_req & i_wb_we & (idx == rhi_pkg::IDX_DATA_HIGH);
  assign wr_ctrl = wb_req & i_wb_we & (idx == rhi_pkg::IDX_CTRL) & i_wb_sel[0];

  // one transfer at a time; lowest set bit wins when several are written
  always_comb begin
    launch_bits = 3'b000;
    if (i_wb_dat[rhi_pkg::CF_IBUSY]) begin
      launch_bits[rhi_pkg::CF_IBUSY] = 1'b1;
    end else if (i_wb_dat[rhi_pkg::CF_DBUSY]) begin
      launch_bits[rhi_pkg::CF_DBUSY] = 1'b1;
    end else if (i_wb_dat[rhi_pkg::CF_RDBUSY]) begin
      launch_bits[rhi_pkg::CF_RDBUSY] = 1'b1;
    end
  end

  assign launch = wr_ctrl && (busy_reg == 3'b000) && (launch_bits != 3'b000);
  assign xfer_done = (st_reg == P_DONE) && lnk.ready;

  // ---------------------------------------------------------------
  // bus answer: ack one cycle after the request, dropped after one
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (idx == rhi_pkg::IDX_DATA_LOW) begin
      rd_mux[15:0] = low_reg;
    end else if (idx == rhi_pkg::IDX_DATA_HIGH) begin
      rd_mux[15:0] = high_reg;
    end else if (idx == rhi_pkg::IDX_CTRL) begin
      rd_mux[rhi_pkg::CF_W-1:0] = {gsck_reg, exec_reg, busy_reg};
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // data registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      low_reg <= rhi_pkg::DATA_RST;
      high_reg <= rhi_pkg::DATA_RST;
    end else if (xfer_done && kind_reg == rhi_pkg::KIND_READ) begin
      high_reg <= sh_reg[31:16];
      low_reg <= sh_reg[15:0];
    end else begin
      if (wr_low && i_wb_sel[0]) begin
        low_reg[7:0] <= i_wb_dat[7:0];
      end
      if (wr_low && i_wb_sel[1]) begin
        low_reg[15:8] <= i_wb_dat[15:8];
      end
      if (wr_high && i_wb_sel[0]) begin
        high_reg[7:0] <= i_wb_dat[7:0];
      end
      if (wr_high && i_wb_sel[1]) begin
        high_reg[15:8] <= i_wb_dat[15:8]; // opcode lane
      end
    end
  end

  // ---------------------------------------------------------------
  // control/status
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      exec_reg <= 1'b0;
      gsck_reg <= 1'b0;
    end else if (wr_ctrl) begin
      exec_reg <= i_wb_dat[rhi_pkg::CF_EXEC]; // held until software clears
      gsck_reg <= i_wb_dat[rhi_pkg::CF_GSCK];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg <= rhi_pkg::CTRL_RST[2:0];
    end else if (launch) begin
      busy_reg <= launch_bits;
    end else if (xfer_done) begin
      busy_reg <= 3'b000; // zero writes never reach here early
    end
  end

  assign lnk.exec = exec_reg;

  // ---------------------------------------------------------------
  // link master; with serial clock generation off a transfer stalls
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= P_IDLE;
      sh_reg <= 32'h0000_0000;
      half_reg <= 8'h00;
      bit_reg <= 5'h00;
      sck_reg <= 1'b0;
      cs_reg <= 1'b0;
      rx_reg <= 1'b0;
      kind_reg <= rhi_pkg::KIND_INSTR;
    end else begin
      unique case (st_reg)
        P_IDLE: begin
          if (launch) begin
            sh_reg <= {high_reg, low_reg};
            cs_reg <= 1'b1;
            half_reg <= 8'h00;
            bit_reg <= 5'h00;
            if (launch_bits[rhi_pkg::CF_IBUSY]) begin
              kind_reg <= rhi_pkg::KIND_INSTR;
            end else if (launch_bits[rhi_pkg::CF_DBUSY]) begin
              kind_reg <= rhi_pkg::KIND_DATA;
            end else begin
              kind_reg <= rhi_pkg::KIND_READ;
            end
            st_reg <= P_PREP;
          end
        end
        P_PREP: begin
          if (lnk.ready) begin
            st_reg <= P_SHIFT; // read waits here while module samples
          end
        end
        P_SHIFT: begin
          if (gsck_reg) begin
            if (half_reg == 8'(SCK_HALF - 1)) begin
              half_reg <= 8'h00;
              sck_reg <= ~sck_reg;
              if (!sck_reg) begin
                rx_reg <= lnk.miso;
              end else begin
                sh_reg <= {sh_reg[30:0], rx_reg}; // msb first
                bit_reg <= bit_reg + 5'h01;
                if (bit_reg == 5'h1f) begin
                  cs_reg <= 1'b0;
                  st_reg <= P_DONE;
                end
              end
            end else begin
              half_reg <= half_reg + 8'h01;
            end
          end
        end
        P_DONE: begin
          if (lnk.ready) begin
            st_reg <= P_IDLE; // module has taken the word
          end
        end
      endcase
    end
  end

  assign lnk.sck = sck_reg;
  assign lnk.cs = cs_reg;
  assign lnk.mosi = sh_reg[31];
  assign lnk.kind = kind_reg;

endmodule : rhi_periph
`default_nettype wire

// >>> verif/rhi_link_monitor.sv
// link checker between the bus peripheral and the clock module
`timescale 1ns/1ps
`default_nettype none
module rhi_link_monitor (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // link signals
  input wire logic sck,
  input wire logic cs,
  input wire logic mosi,
  input var rhi_pkg::rhi_kind_e kind,
  input wire logic exec,
  input wire logic miso,
  input wire logic ready
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic sck_q;
  logic [5:0] rise_cnt;

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
    end
  end

  // counts serial clock rises inside one frame
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_cnt <= 6'h00;
    end else if (!cs) begin
      rise_cnt <= 6'h00;
    end else if (sck && !sck_q) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  // half periods assume the default of four cycles
  sequence high_phase;
    sck [*4] ##1 !sck;
  endsequence
  sequence low_phase;
    !sck [*4];
  endsequence

  sck_idle_a: assert property (!cs |-> !sck)
    else $error("serial clock moved outside a frame");
  sck_high_a: assert property ($rose(sck) |-> high_phase)
    else $error("serial clock high phase has wrong length");
  sck_low_a: assert property ($fell(sck) && cs |-> low_phase)
    else $error("serial clock low phase too short");
  frame_bits_a: assert property ($fell(cs) |-> rise_cnt == 6'h20)
    else $error("frame did not carry 32 clocks");
  kind_stable_a: assert property (cs && $past(cs) |-> $stable(kind))
    else $error("transfer kind changed within a frame");
  mosi_stable_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data out changed while serial clock high");
  cs_start_a: assert property ($rose(cs) |-> !sck)
    else $error("frame opened with serial clock high");
  cs_min_a: assert property ($rose(cs) |-> cs [*8])
    else $error("frame closed too early");
  ready_open_a: assert property ($rose(cs) |-> !ready)
    else $error("link ready while frame opening");
  miso_stable_a: assert property (sck && $past(sck) |-> $stable(miso))
    else $error("data in changed while serial clock high");
endmodule : rhi_link_monitor
`default_nettype wire

// >>> verif/rtc_host_interface_test.sv
// self-checking bench for the peripheral and clock module pair
`timescale 1ns/1ps
`default_nettype none
module rtc_host_interface_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n, cyc, stb, we, ack, osc, osc_on, alarm, sck_q, cs_q;
  logic [17:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, seconds, shift_cap, word_cap, seed, v, q, q2;
  logic [2:0] osc_cnt = 3'h0;
  int failures, checks_done, i, n;

  rhi_link_if lnk ();
  rhi_periph u_rhi_periph (.i_clk_sys(clk_sys), .i_resetn(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .lnk(lnk));
  // shrunk dividers keep a second at 160 cycles
  rhi_clock_module #(.OSC_DIV(4), .PHASE_DIV(4)) u_rhi_clock_module (.i_clk_sys(clk_sys),
    .i_resetn(rst_n), .lnk(lnk), .i_osc_32k(osc), .o_alarm(alarm), .o_seconds(seconds));
  rhi_link_monitor u_rhi_link_monitor (.i_clk_sys(clk_sys), .i_resetn(rst_n), .sck(lnk.sck),
    .cs(lnk.cs), .mosi(lnk.mosi), .kind(lnk.kind), .exec(lnk.exec), .miso(lnk.miso), .ready(lnk.ready));

  always #10 clk_sys = ~clk_sys;

  // oscillator toggles every 5 cycles, so a rise every 10
  always @(posedge clk_sys) begin
    osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
    if (osc_on && osc_cnt == 3'h4) osc <= ~osc;
  end

  // wire-side capture of each frame, msb first
  always @(posedge clk_sys) begin
    sck_q <= lnk.sck;
    cs_q <= lnk.cs;
    if (lnk.sck && !sck_q) shift_cap <= {shift_cap[30:0], lnk.mosi};
    if (!lnk.cs && cs_q) word_cap <= shift_cap;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) failures++;
  endtask : wb

  task automatic xfer(input logic [4:0] bits, input logic [31:0] w);
    logic [31:0] r;
    int k;
    wb(1'b1, rhi_pkg::IDX_DATA_HIGH, {16'h0, w[31:16]}, r);
    wb(1'b1, rhi_pkg::IDX_DATA_LOW, {16'h0, w[15:0]}, r);
    wb(1'b1, rhi_pkg::IDX_CTRL, {27'h0, bits | 5'h10}, r);
    k = 0;
    do begin
      wb(1'b0, rhi_pkg::IDX_CTRL, 32'h0, r);
      k++;
    end while (r[2:0] !== 3'h0 && k < 400);
    check("busy flags", {29'h0, r[2:0]}, 32'h0);
  endtask : xfer

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, osc} = 4'h0;
    osc_on = 1'b1;
    adr = 18'h0;
    sel = 4'hf;
    wdat = 32'h0;
    seed = 32'hc94fcdb3;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wb(1'b0, rhi_pkg::IDX_DATA_LOW + 16'(i), 32'h0, q);
      check("reset value", q, 32'h0);
    end
    wb(1'b1, 16'hfea3, seed, q);
    wb(1'b0, 16'hfea3, 32'h0, q);
    check("unmapped read", q, 32'h0);
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wb(1'b1, rhi_pkg::IDX_DATA_LOW, seed, q);
      wb(1'b1, rhi_pkg::IDX_DATA_HIGH, seed >> 16, q);
      wb(1'b0, rhi_pkg::IDX_DATA_LOW, 32'h0, q);
      wb(1'b0, rhi_pkg::IDX_DATA_HIGH, 32'h0, q2);
      check("data regs", {q2[15:0], q[15:0]}, seed);
    end
    // launch without serial clock: the frame must wait
    wb(1'b1, rhi_pkg::IDX_DATA_HIGH, 32'h5600, q);
    wb(1'b1, rhi_pkg::IDX_DATA_LOW, 32'h0, q);
    wb(1'b1, rhi_pkg::IDX_CTRL, 32'h01, q);
    repeat (40) @(posedge clk_sys);
    wb(1'b0, rhi_pkg::IDX_CTRL, 32'h0, q);
    check("stalled busy", q, 32'h01);
    check("frame open", {31'h0, lnk.cs}, 32'h1);
    wb(1'b1, rhi_pkg::IDX_CTRL, 32'h10, q);
    wb(1'b0, rhi_pkg::IDX_CTRL, 32'h0, q);
    check("zero to busy", q, 32'h11);
    xfer(5'h00, 32'h00005600);
    check("instr word", word_cap, 32'h56000000);
    // load a random time and wait out the 128-tick execute delay
    seed = lfsr(seed);
    v = seed;
    xfer(5'h02, v);
    check("data word", word_cap, v);
    xfer(5'h01, {rhi_pkg::OP_LOAD_TIME, 24'h0});
    wb(1'b1, rhi_pkg::IDX_CTRL, 32'h18, q);
    wb(1'b0, rhi_pkg::IDX_CTRL, 32'h0, q);
    check("exec set", q, 32'h18);
    repeat (2000) @(posedge clk_sys);
    check("early load", {31'h0, seconds === v}, 32'h0);
    n = 0;
    while (seconds !== v && n < 8000) begin
      @(posedge clk_sys);
      n++;
    end
    osc_on <= 1'b0;
    check("loaded seconds", seconds, v);
    wb(1'b1, rhi_pkg::IDX_CTRL, 32'h10, q);
    // frozen oscillator makes the read value exact
    xfer(5'h01, {rhi_pkg::OP_READ_TIME, 24'h0});
    xfer(5'h04, 32'h0);
    wb(1'b0, rhi_pkg::IDX_DATA_HIGH, 32'h0, q);
    wb(1'b0, rhi_pkg::IDX_DATA_LOW, 32'h0, q2);
    check("read seconds", {q[15:0], q2[15:0]}, v);
    xfer(5'h01, {rhi_pkg::OP_READ_SUBSEC, 24'h0});
    // ones in the data registers so a missing load shows
    xfer(5'h04, 32'hffff_ffff);
    wb(1'b0, rhi_pkg::IDX_DATA_HIGH, 32'h0, q);
    wb(1'b0, rhi_pkg::IDX_DATA_LOW, 32'h0, q2);
    check("phase range", {q[15:0], q2[15:2], 2'h0}, 32'h0);
    // alarm one second ahead, then time one second
    xfer(5'h02, v + 32'h1);
    xfer(5'h01, {rhi_pkg::OP_ALARM, 24'h0});
    osc_on <= 1'b1;
    n = 0;
    while (alarm !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check("alarm time", seconds, v + 32'h1);
    q = seconds;
    n = 0;
    while (seconds === q && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    q = seconds;
    n = 0;
    while (seconds === q && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    check("second length", 32'(n), 32'(4 * 4 * 10));
    // reset instruction must disarm an alarm set 48 seconds ahead, past the 32-second execute delay
    q = seconds + 32'h30;
    xfer(5'h02, q);
    xfer(5'h01, {rhi_pkg::OP_ALARM, 24'h0});
    xfer(5'h01, {rhi_pkg::OP_RESET, 24'h0});
    wb(1'b1, rhi_pkg::IDX_CTRL, 32'h18, q2);
    n = 0;
    i = 0;
    while (seconds !== q + 32'h1 && n < 14000) begin
      @(posedge clk_sys);
      if (alarm !== 1'b0) i++;
      n++;
    end
    wb(1'b1, rhi_pkg::IDX_CTRL, 32'h10, q2);
    check("alarm after reset", 32'(i), 32'h0);
    check("alarm time passed", seconds, q + 32'h1);
    summarize();
  end

  // whole run needs about 20000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule : rtc_host_interface_test
`default_nettype wire
